// *** inc/dsp_data_pkg.sv ***
// Shared widths, encodings and constants of the fractional data unit
package dsp_data_pkg;
   // =====================================================
   // Widths
   localparam int WORD_W = 24;
   localparam int BODY_W = 48;
   localparam int EXT_W = 8;
   localparam int ACC_W = 56;
   // =====================================================
   // Values
   localparam logic [23:0] WORD_RST = 24'h000000;
   localparam logic [55:0] ACC_RST = 56'h00000000000000;
   localparam logic [47:0] SAT_POS = 48'h7FFFFFFFFFFF;
   localparam logic [47:0] SAT_NEG = 48'h800000000000;
   localparam logic [23:0] SAT_POS_W = 24'h7FFFFF;
   localparam logic [23:0] SAT_NEG_W = 24'h800000;
   localparam logic [55:0] RND_HALF = 56'h00000000800000;
   localparam logic [23:0] LOW_HALF = 24'h800000;
   localparam int RND_BIT = 24;
   // =====================================================
   // Encodings
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_MPY = 4'h1, OP_MPYN = 4'h2, OP_MAC = 4'h3,
      OP_MACN = 4'h4, OP_RND = 4'h5, OP_ASL = 4'h6, OP_ASR = 4'h7,
      OP_AND = 4'h8, OP_OR = 4'h9, OP_EOR = 4'hA, OP_ADD = 4'hB,
      OP_SUB = 4'hC, OP_ADDL = 4'hD, OP_CLR = 4'hE, OP_TFR = 4'hF
   } alu_op_t;
   typedef enum logic [1:0] {
      XFER_NONE = 2'h0, XFER_WR = 2'h1, XFER_RD = 2'h2
   } xfer_t;
   typedef enum logic [2:0] {
      SEL_X0 = 3'h0, SEL_X1 = 3'h1, SEL_Y0 = 3'h2, SEL_Y1 = 3'h3,
      SEL_A = 3'h4, SEL_B = 3'h5
   } reg_sel_t;
   typedef enum logic [1:0] {
      SCALE_NONE = 2'h0, SCALE_DOWN = 2'h1, SCALE_UP = 2'h2
   } scale_t;
   // Register selects 4 and 5 name the accumulators
   function automatic logic sel_is_acc(input reg_sel_t s);
      return s == SEL_A || s == SEL_B;
   endfunction
endpackage

// *** inc/mac_if.sv ***
// Operand and result path between the data unit and its multiplier
`timescale 1ns/1ps
interface mac_if;
   logic signed [23:0] src1;
   logic signed [23:0] src2;
   logic [55:0] acc_in;
   logic negate;
   logic accumulate;
   logic [55:0] result;
   modport core(output src1, src2, acc_in, negate, accumulate,
                input result);
   modport unit(input src1, src2, acc_in, negate, accumulate,
                output result);
endinterface

// *** hw/frac_mac.sv ***
// Single-cycle fractional multiply-accumulate
`timescale 1ns/1ps
module frac_mac (
   mac_if.unit m
);
   import dsp_data_pkg::*;
   logic signed [47:0] prod;
   logic [55:0] prod_ext;
   logic [55:0] term;
   // =====================================================
   // Product
   always_comb begin
      prod = m.src1 * m.src2;
      prod_ext = {{7{prod[47]}}, prod, 1'b0};
      term = m.negate ? (ACC_RST - prod_ext) : prod_ext;
      m.result = m.accumulate ? (m.acc_in + term) : term;
   end
endmodule

// *** hw/out_limiter.sv ***
// Output shifter and limiter for one data bus
`timescale 1ns/1ps
module out_limiter (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [55:0] acc,
   input wire dsp_data_pkg::scale_t scale,
   output logic [47:0] value,
   output logic ovf
);
   import dsp_data_pkg::*;
   logic [56:0] shifted;
   // =====================================================
   // Scale and limit
   always_comb begin
      case (scale)
         SCALE_DOWN: shifted = {acc[55], acc[55], acc[55:1]};
         SCALE_UP: shifted = {acc, 1'b0};
         default: shifted = {acc[55], acc};
      endcase
      ovf = !(&shifted[56:47] || ~|shifted[56:47]);
      if (!ovf) begin
         value = shifted[47:0];
      end else if (shifted[56]) begin
         value = SAT_NEG;
      end else begin
         value = SAT_POS;
      end
   end
   // =====================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   up_shift_a: assert property (
      scale == SCALE_UP && !ovf |-> value == acc[46:0] * 2)
      else $error("left scaling gave wrong value");
   down_shift_a: assert property (
      scale == SCALE_DOWN && !ovf |-> value == acc[48:1])
      else $error("right scaling gave wrong value");
   sat_sign_a: assert property (
      ovf |-> value == (acc[55] ? SAT_NEG : SAT_POS))
      else $error("limited value does not follow sign");
endmodule

// *** hw/frac_data_unit.sv ***
// Fractional arithmetic data unit with two bus shifter/limiters
// Notes on behaviour
// - Four 24-bit inputs, two 56-bit accumulators.
// - Arithmetic is fractional two's complement.
// - Registers move over buses, 24 or 48 bits.
// - Every operation completes in one cycle.
// - Multiplier is parallel, single cycle, unpipelined.
// - Operands only from unit registers, 24/48/56.
// - Results land only in an accumulator.
// - One shifter/limiter per data bus.
// - Shifter passes, shifts left or right.
// - Scaling chosen by mode bits, not code.
// - Limiter gives 48 bits plus overflow; a word read takes the upper 24, a long read takes all 48.
// - Unrepresentable values limit by sign, flag error.
// - X and Y transfers in same cycle.
// - Both buses join for 48-bit values.
// - Data buses are 24-bit and two-way.
`timescale 1ns/1ps
module frac_data_unit (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire dsp_data_pkg::alu_op_t alu_op,
   input wire logic [1:0] src_a,
   input wire logic [1:0] src_b,
   input wire logic dest_b,
   input wire dsp_data_pkg::xfer_t x_xfer,
   input wire dsp_data_pkg::reg_sel_t x_reg,
   input wire dsp_data_pkg::xfer_t y_xfer,
   input wire dsp_data_pkg::reg_sel_t y_reg,
   input wire dsp_data_pkg::xfer_t long_xfer,
   input wire logic long_acc,
   input wire dsp_data_pkg::scale_t scale_mode,
   input wire logic limit_clear,
   input wire logic [23:0] x_data_bus_in,
   output logic [23:0] x_data_bus_out,
   output logic x_data_bus_oe,
   input wire logic [23:0] y_data_bus_in,
   output logic [23:0] y_data_bus_out,
   output logic y_data_bus_oe,
   output logic limit_flag
);
   import dsp_data_pkg::*;
   // =====================================================
   // State
   typedef struct packed {
      logic [3:0][23:0] inr;
      logic [1:0][55:0] acc;
      logic [1:0][23:0] bout;
      logic [1:0] boe;
      logic flag;
   } state_t;
   state_t q;
   state_t d;
   mac_if m();
   logic [1:0][23:0] bin;
   xfer_t [1:0] bxfer;
   reg_sel_t [1:0] breg;
   logic [1:0] lim_sel;
   logic [1:0][47:0] lim_val;
   logic [1:0] lim_ovf;
   logic [1:0] ovf_evt;
   logic [55:0] rsum;
   logic [47:0] pair;
   // =====================================================
   // Bus views
   assign bin[0] = x_data_bus_in;
   assign bin[1] = y_data_bus_in;
   assign bxfer[0] = x_xfer;
   assign bxfer[1] = y_xfer;
   assign breg[0] = x_reg;
   assign breg[1] = y_reg;
   // =====================================================
   // Multiplier
   // operands from input registers
   assign m.src1 = q.inr[src_a];
   assign m.src2 = q.inr[src_b];
   assign m.acc_in = q.acc[dest_b];
   assign m.negate = alu_op == OP_MPYN || alu_op == OP_MACN;
   assign m.accumulate = alu_op == OP_MAC || alu_op == OP_MACN;
   frac_mac u_mac (
      .m(m)
   );
   // =====================================================
   // Shifter/limiters
   // one unit per bus
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_lim
         always_comb begin
            if (long_xfer != XFER_NONE) begin
               lim_sel[gi] = long_acc;
            end else begin
               lim_sel[gi] = breg[gi] == SEL_B;
            end
         end
         out_limiter u_lim (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .acc(q.acc[lim_sel[gi]]),
            .scale(scale_mode),
            .value(lim_val[gi]),
            .ovf(lim_ovf[gi])
         );
      end
   endgenerate
   // =====================================================
   // Next state
   always_comb begin
      d = q;
      d.boe = 2'b00;
      ovf_evt = 2'b00;
      rsum = q.acc[dest_b] + RND_HALF;
      pair = src_a[1] ? {q.inr[3], q.inr[2]} : {q.inr[1], q.inr[0]};
      case (alu_op)
         OP_MPY, OP_MPYN, OP_MAC, OP_MACN: begin
            d.acc[dest_b] = m.result;
         end
         OP_RND: begin
            // Convergent: exact half rounds to even
            if (q.acc[dest_b][23:0] == LOW_HALF) begin
               rsum[RND_BIT] = 1'b0;
            end
            rsum[23:0] = WORD_RST;
            d.acc[dest_b] = rsum;
         end
         OP_ASL: begin
            d.acc[dest_b] = {q.acc[dest_b][54:0], 1'b0};
         end
         OP_ASR: begin
            d.acc[dest_b] = {q.acc[dest_b][55], q.acc[dest_b][55:1]};
         end
         OP_AND: begin
            d.acc[dest_b][47:24] = q.acc[dest_b][47:24] & q.inr[src_a];
         end
         OP_OR: begin
            d.acc[dest_b][47:24] = q.acc[dest_b][47:24] | q.inr[src_a];
         end
         OP_EOR: begin
            d.acc[dest_b][47:24] = q.acc[dest_b][47:24] ^ q.inr[src_a];
         end
         OP_ADD: begin
            d.acc[dest_b] = q.acc[dest_b] + q.acc[!dest_b];
         end
         OP_SUB: begin
            d.acc[dest_b] = q.acc[dest_b] - q.acc[!dest_b];
         end
         OP_ADDL: begin
            d.acc[dest_b] = q.acc[dest_b] + {{8{pair[47]}}, pair};
         end
         OP_TFR: begin
            d.acc[dest_b] = q.acc[!dest_b];
         end
         OP_CLR: begin
            d.acc[dest_b] = ACC_RST;
         end
         default: begin
            d.acc = q.acc;
         end
      endcase
      if (long_xfer == XFER_WR) begin
         d.acc[long_acc] = {{8{bin[0][23]}}, bin[0], bin[1]};
      end else if (long_xfer == XFER_RD) begin
         d.bout[0] = lim_val[0][47:24];
         d.bout[1] = lim_val[1][23:0];
         d.boe = 2'b11;
         ovf_evt = lim_ovf;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (bxfer[i] == XFER_WR) begin
               if (sel_is_acc(breg[i])) begin
                  d.acc[breg[i][0]] = {{8{bin[i][23]}}, bin[i], WORD_RST};
               end else begin
                  d.inr[breg[i][1:0]] = bin[i];
               end
            end else if (bxfer[i] == XFER_RD) begin
               d.boe[i] = 1'b1;
               if (sel_is_acc(breg[i])) begin
                  d.bout[i] = lim_val[i][47:24];
                  ovf_evt[i] = lim_ovf[i];
               end else begin
                  d.bout[i] = q.inr[breg[i][1:0]];
               end
            end
         end
      end
      d.flag = (|ovf_evt) | (q.flag & ~limit_clear);
   end
   // =====================================================
   // Registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q.inr <= {4{WORD_RST}};
         q.acc <= {2{ACC_RST}};
         q.bout <= {2{WORD_RST}};
         q.boe <= 2'b00;
         q.flag <= 1'b0;
      end else begin
         q <= d;
      end
   end
   assign x_data_bus_out = q.bout[0];
   assign y_data_bus_out = q.bout[1];
   assign x_data_bus_oe = q.boe[0];
   assign y_data_bus_oe = q.boe[1];
   assign limit_flag = q.flag;
   // =====================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   logic signed [47:0] mac_prod;
   assign mac_prod = m.src1 * m.src2;
   sequence x_acc_rd;
      long_xfer == XFER_NONE && x_xfer == XFER_RD && sel_is_acc(x_reg);
   endsequence
   sequence x_ovf_rd;
      x_acc_rd ##0 lim_ovf[0];
   endsequence
   sequence y_acc_rd;
      long_xfer == XFER_NONE && y_xfer == XFER_RD && sel_is_acc(y_reg);
   endsequence
   sequence y_ovf_rd;
      y_acc_rd ##0 lim_ovf[1];
   endsequence
   sat_word_a: assert property (
      x_ovf_rd |=> x_data_bus_out ==
      ($past(q.acc[lim_sel[0]][55]) ? SAT_NEG_W : SAT_POS_W))
      else $error("x bus did not carry the limit value");
   y_sat_word_a: assert property (
      y_ovf_rd |=> y_data_bus_out ==
      ($past(q.acc[lim_sel[1]][55]) ? SAT_NEG_W : SAT_POS_W))
      else $error("y bus did not carry the limit value");
   flag_set_a: assert property (
      x_ovf_rd |=> limit_flag ##1 (limit_flag || $past(limit_clear)))
      else $error("overflow flag not raised");
   y_flag_set_a: assert property (
      y_ovf_rd |=> limit_flag)
      else $error("overflow flag not raised by y read");
   flag_hold_a: assert property (
      limit_flag && !limit_clear |=> limit_flag)
      else $error("overflow flag dropped without clear");
   flag_clr_a: assert property (
      limit_clear && ovf_evt == 2'b00 |=> !limit_flag)
      else $error("overflow flag not cleared");
   bus_oe_a: assert property (
      long_xfer == XFER_NONE |=>
      x_data_bus_oe == ($past(x_xfer) == XFER_RD))
      else $error("x bus enable does not follow read");
   y_bus_oe_a: assert property (
      long_xfer == XFER_NONE |=>
      y_data_bus_oe == ($past(y_xfer) == XFER_RD))
      else $error("y bus enable does not follow read");
   in_read_a: assert property (
      long_xfer == XFER_NONE && x_xfer == XFER_RD && !sel_is_acc(x_reg) |=>
      x_data_bus_out == $past(q.inr[x_reg[1:0]]))
      else $error("x bus read of input register wrong");
   dual_wr_a: assert property (
      long_xfer == XFER_NONE && x_xfer == XFER_WR && x_reg == SEL_X0 &&
      y_xfer == XFER_WR && y_reg == SEL_Y0 |=>
      q.inr[0] == $past(x_data_bus_in) && q.inr[2] == $past(y_data_bus_in))
      else $error("parallel writes not both taken");
   long_rd_a: assert property (
      long_xfer == XFER_RD && scale_mode == SCALE_NONE &&
      !lim_ovf[0] |=> {x_data_bus_out, y_data_bus_out} ==
      $past(q.acc[long_acc][47:0]) && y_data_bus_oe)
      else $error("long read did not split across buses");
   long_wr_a: assert property (
      long_xfer == XFER_WR |=> q.acc[$past(long_acc)] ==
      {{8{$past(x_data_bus_in[23])}}, $past(x_data_bus_in),
      $past(y_data_bus_in)})
      else $error("long write did not join the buses");
   mac_step_a: assert property (
      alu_op == OP_MAC && !dest_b && long_xfer == XFER_NONE &&
      x_xfer != XFER_WR && y_xfer != XFER_WR |=>
      q.acc[0] == $past(q.acc[0]) + {{7{$past(mac_prod[47])}},
      $past(mac_prod), 1'b0})
      else $error("multiply-accumulate result not ready next cycle");
   inputs_kept_a: assert property (
      x_xfer != XFER_WR && y_xfer != XFER_WR |=> $stable(q.inr))
      else $error("operation wrote a non-accumulator register");
   other_acc_a: assert property (
      long_xfer == XFER_NONE && x_xfer != XFER_WR && y_xfer != XFER_WR |=>
      q.acc[!$past(dest_b)] == $past(q.acc[!dest_b]))
      else $error("operation wrote the other accumulator");
   tfr_copy_a: assert property (
      alu_op == OP_TFR && long_xfer == XFER_NONE && x_xfer != XFER_WR &&
      y_xfer != XFER_WR |=> q.acc[$past(dest_b)] == $past(q.acc[!dest_b]))
      else $error("transfer did not copy the other accumulator");
   clr_acc_a: assert property (
      alu_op == OP_CLR && long_xfer == XFER_NONE && x_xfer != XFER_WR &&
      y_xfer != XFER_WR |=> q.acc[$past(dest_b)] == ACC_RST)
      else $error("clear left the accumulator set");
   rnd_clear_a: assert property (
      alu_op == OP_RND && long_xfer != XFER_WR && x_xfer != XFER_WR &&
      y_xfer != XFER_WR |=> q.acc[$past(dest_b)][23:0] == WORD_RST)
      else $error("rounding left low bits set");
endmodule

// *** tb/data_mem_model.sv ***
// Behavioural X and Y data memories facing the two data buses
`timescale 1ns/1ps
module data_mem_model (
   input wire logic clk_sys,
   input wire logic x_drive,
   input wire logic [23:0] x_word,
   input wire logic y_drive,
   input wire logic [23:0] y_word,
   input wire logic [23:0] x_data_bus_out,
   input wire logic x_data_bus_oe,
   input wire logic [23:0] y_data_bus_out,
   input wire logic y_data_bus_oe,
   output logic [23:0] x_data_bus_in,
   output logic [23:0] y_data_bus_in
);
   logic [23:0] x_last_q = 24'h000000;
   logic [23:0] y_last_q = 24'h000000;
   // =====================================================
   // Wire levels
   // two-way word buses
   always_comb begin
      x_data_bus_in = x_drive ? x_word :
                      (x_data_bus_oe ? x_data_bus_out : ~x_last_q);
      y_data_bus_in = y_drive ? y_word :
                      (y_data_bus_oe ? y_data_bus_out : ~y_last_q);
   end
   // Released bus shows no stale word
   always @(posedge clk_sys) begin
      if (x_drive) begin
         x_last_q <= x_word;
      end
      if (y_drive) begin
         y_last_q <= y_word;
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the fractional data unit
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
   import dsp_data_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   alu_op_t alu_op = OP_NOP;
   logic [1:0] src_a = 2'h0;
   logic [1:0] src_b = 2'h0;
   logic dest_b = 1'b0;
   xfer_t x_xfer = XFER_NONE;
   reg_sel_t x_reg = SEL_X0;
   xfer_t y_xfer = XFER_NONE;
   reg_sel_t y_reg = SEL_X0;
   xfer_t long_xfer = XFER_NONE;
   logic long_acc = 1'b0;
   scale_t scale_mode = SCALE_NONE;
   logic limit_clear = 1'b0;
   logic x_drive = 1'b0;
   logic y_drive = 1'b0;
   logic [23:0] x_word = 24'h000000;
   logic [23:0] y_word = 24'h000000;
   logic [23:0] x_data_bus_in, x_data_bus_out, y_data_bus_in, y_data_bus_out;
   logic x_data_bus_oe, y_data_bus_oe, limit_flag;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] seed = 32'hF9442285;
   logic [23:0] regs [4] = '{default: 24'h000000};
   logic [55:0] acc [2] = '{default: 56'h00000000000000};
   logic flag_exp = 1'b0;
   logic [23:0] corner [4] = '{24'h400000, 24'hBFFFFF, 24'h3FFFFF, 24'h800000};
   always #2.5 clk_sys = ~clk_sys;
   frac_data_unit i_frac_data_unit (.clk_sys(clk_sys), .reset_n(reset_n),
      .alu_op(alu_op), .src_a(src_a), .src_b(src_b), .dest_b(dest_b),
      .x_xfer(x_xfer), .x_reg(x_reg), .y_xfer(y_xfer), .y_reg(y_reg),
      .long_xfer(long_xfer), .long_acc(long_acc), .scale_mode(scale_mode),
      .limit_clear(limit_clear), .x_data_bus_in(x_data_bus_in),
      .x_data_bus_out(x_data_bus_out), .x_data_bus_oe(x_data_bus_oe),
      .y_data_bus_in(y_data_bus_in), .y_data_bus_out(y_data_bus_out),
      .y_data_bus_oe(y_data_bus_oe), .limit_flag(limit_flag));
   data_mem_model i_data_mem_model (.clk_sys(clk_sys), .x_drive(x_drive),
      .x_word(x_word), .y_drive(y_drive), .y_word(y_word),
      .x_data_bus_out(x_data_bus_out), .x_data_bus_oe(x_data_bus_oe),
      .y_data_bus_out(y_data_bus_out), .y_data_bus_oe(y_data_bus_oe),
      .x_data_bus_in(x_data_bus_in), .y_data_bus_in(y_data_bus_in));
   // =====================================================
   // Expectation functions
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [55:0] prod(logic [23:0] p, logic [23:0] q);
      logic signed [55:0] r;
      r = $signed(p) * $signed(q);
      return r <<< 1;
   endfunction
   function automatic logic [48:0] lim(logic [55:0] v, scale_t s);
      logic [56:0] t;
      t = (s == SCALE_DOWN) ? {v[55], v[55], v[55:1]} :
          ((s == SCALE_UP) ? {v, 1'b0} : {v[55], v});
      if (t[56:47] == {10{t[56]}}) begin
         return {1'b0, t[47:0]};
      end
      return {1'b1, t[56] ? SAT_NEG : SAT_POS};
   endfunction
   function automatic logic [48:0] exp_rd(reg_sel_t r, scale_t s);
      if (r > SEL_Y1) begin
         return lim(acc[r == SEL_B], s);
      end
      return {1'b0, regs[r[1:0]], 24'h000000};
   endfunction
   // =====================================================
   // Bus and operation tasks
   task automatic step();
      @(posedge clk_sys);
      @(negedge clk_sys);
      alu_op = OP_NOP;
      x_xfer = XFER_NONE;
      y_xfer = XFER_NONE;
      long_xfer = XFER_NONE;
      x_drive = 1'b0;
      y_drive = 1'b0;
      limit_clear = 1'b0;
   endtask
   task automatic wr2(reg_sel_t xr, logic [23:0] xv, reg_sel_t yr,
                      logic [23:0] yv);
      x_xfer = XFER_WR;
      x_reg = xr;
      x_word = xv;
      x_drive = 1'b1;
      y_xfer = XFER_WR;
      y_reg = yr;
      y_word = yv;
      y_drive = 1'b1;
      step();
      if (xr > SEL_Y1) acc[xr == SEL_B] = {{8{xv[23]}}, xv, 24'h000000};
      else regs[xr[1:0]] = xv;
      if (yr > SEL_Y1) acc[yr == SEL_B] = {{8{yv[23]}}, yv, 24'h000000};
      else regs[yr[1:0]] = yv;
   endtask
   task automatic rd2(reg_sel_t xr, reg_sel_t yr, scale_t s);
      logic [48:0] ex;
      logic [48:0] ey;
      ex = exp_rd(xr, s);
      ey = exp_rd(yr, s);
      x_xfer = XFER_RD;
      x_reg = xr;
      y_xfer = XFER_RD;
      y_reg = yr;
      scale_mode = s;
      step();
      flag_exp = flag_exp | ex[48] | ey[48];
      `CHK(x_data_bus_out, ex[47:24])
      `CHK(y_data_bus_out, ey[47:24])
      `CHK({x_data_bus_oe, y_data_bus_oe}, 2'h3)
      `CHK(limit_flag, flag_exp)
   endtask
   task automatic wr_long(logic d, logic [47:0] v);
      long_xfer = XFER_WR;
      long_acc = d;
      x_word = v[47:24];
      y_word = v[23:0];
      x_drive = 1'b1;
      y_drive = 1'b1;
      step();
      acc[d] = {{8{v[47]}}, v};
   endtask
   task automatic rd_long(logic d);
      logic [48:0] e;
      e = lim(acc[d], SCALE_NONE);
      long_xfer = XFER_RD;
      long_acc = d;
      scale_mode = SCALE_NONE;
      flag_exp = flag_exp & !limit_clear;
      step();
      flag_exp = flag_exp | e[48];
      `CHK({x_data_bus_out, y_data_bus_out}, e[47:0])
      `CHK(limit_flag, flag_exp)
   endtask
   task automatic op(alu_op_t o, logic [1:0] a, logic [1:0] b, logic d);
      logic [55:0] r;
      logic [47:0] pr;
      alu_op = o;
      src_a = a;
      src_b = b;
      dest_b = d;
      step();
      r = acc[d];
      pr = a[1] ? {regs[3], regs[2]} : {regs[1], regs[0]};
      case (o)
         OP_MPY: r = prod(regs[a], regs[b]);
         OP_MPYN: r = -prod(regs[a], regs[b]);
         OP_MAC: r = r + prod(regs[a], regs[b]);
         OP_MACN: r = r - prod(regs[a], regs[b]);
         OP_RND: r = {r + RND_HALF} & ~56'h000000FFFFFF &
                     ~{31'h0, acc[d][23:0] == LOW_HALF, 24'h0};
         OP_ASL: r = r << 1;
         OP_ASR: r = {r[55], r[55:1]};
         OP_AND: r[47:24] = r[47:24] & regs[a];
         OP_OR: r[47:24] = r[47:24] | regs[a];
         OP_EOR: r[47:24] = r[47:24] ^ regs[a];
         OP_ADD: r = r + acc[!d];
         OP_SUB: r = r - acc[!d];
         OP_ADDL: r = r + {{8{pr[47]}}, pr};
         OP_TFR: r = acc[!d];
         OP_CLR: r = 56'h00000000000000;
         default: r = acc[d];
      endcase
      acc[d] = r;
   endtask
   task automatic stop_test();
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   // =====================================================
   // Main sequence
   initial begin
      logic [63:0] w;
      alu_op_t o;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1'b1;
      `CHK({x_data_bus_oe, y_data_bus_oe, limit_flag}, 3'h0)
      for (int i = 0; i < 40; i++) begin
         w = {rnd(), rnd()};
         wr2(SEL_X0, rnd(), SEL_Y0, rnd());
         wr2(SEL_X1, rnd(), SEL_Y1, rnd());
         wr2(reg_sel_t'({2'h2, w[63]}), w[23:0], SEL_X0, w[47:24]);
         rd2(reg_sel_t'(w[52:50] % 3'h6), reg_sel_t'(w[55:53] % 3'h6),
             scale_t'(w[49:48]));
      end
      // Limiter corners under every scale code
      foreach (corner[k]) begin
         for (int s = 0; s < 4; s++) begin
            wr2(SEL_A, corner[k], SEL_B, ~corner[k]);
            rd2(SEL_A, SEL_B, scale_t'(s));
         end
      end
      limit_clear = 1'b1;
      step();
      flag_exp = 1'b0;
      `CHK(limit_flag, 1'b0)
      for (int i = 0; i < 150; i++) begin
         w = {rnd(), rnd()};
         o = alu_op_t'(w[57:54]);
         wr2(SEL_X0, rnd(), SEL_Y1, rnd());
         if (w[62]) wr_long(w[61], w[47:0]);
         op(o, w[60:59], w[53:52], w[63]);
         op(OP_MAC, w[51:50], w[49:48], w[63]);
         limit_clear = w[58];
         rd_long(w[63]);
         rd_long(!w[63]);
         rd2(SEL_A, SEL_B, scale_t'(w[49:48]));
      end
      // Convergent rounding of one exact tie and three other low fractions
      foreach (corner[k]) begin
         wr_long(1'b0, {22'h0, k[1:0], corner[k]});
         op(OP_RND, 2'h0, 2'h0, 1'b0);
         rd_long(1'b0);
      end
      stop_test();
   end
endmodule
